/* File: cmbf_defines.svh */
// Constants for the CAN message buffer, filter and interrupt core.
`ifndef CMBF_DEFINES_SVH
`define CMBF_DEFINES_SVH
// ********************************************************************
// Register byte offsets
// ********************************************************************
`define CMBF_OFS_RFLG 12'h000
`define CMBF_OFS_RIER 12'h004
`define CMBF_OFS_TFLG 12'h008
`define CMBF_OFS_TCTL 12'h00C
`define CMBF_OFS_FCTL 12'h010
`define CMBF_OFS_PAT 12'h014
`define CMBF_OFS_MSK 12'h018
`define CMBF_OFS_RANK0 12'h01C
`define CMBF_OFS_RANK1 12'h020
`define CMBF_OFS_RANK2 12'h024
`define CMBF_OFS_STAT 12'h028
`define CMBF_OFS_TXBUF 12'h040
`define CMBF_OFS_TXEND 12'h0A0
// ********************************************************************
// Field layouts and limits
// ********************************************************************
`define CMBF_NBUF 3
`define CMBF_NBYTE 13
`define CMBF_NWORD 4
`define CMBF_WARN_LIM 9'h060
`define CMBF_PASS_LIM 9'h07F
`define CMBF_BOFF_LIM 9'h0FF
`define CMBF_RANK_RST 8'h00
`define CMBF_TXE_RST 3'h7
`endif

/* File: cmbf_pkg.sv */
// Types for the CAN message buffer, filter and interrupt core.
package cmbf_pkg;
    typedef enum logic [1:0] {
        CMBF_FILT_SINGLE = 2'b00,
        CMBF_FILT_DUAL = 2'b01,
        CMBF_FILT_QUAD = 2'b10,
        CMBF_FILT_CLOSED = 2'b11
    } cmbf_filt_e;
    typedef enum logic [1:0] {
        CMBF_TX_IDLE = 2'b00,
        CMBF_TX_REQ = 2'b01,
        CMBF_TX_BUSY = 2'b11
    } cmbf_tx_e;
    typedef struct packed {
        logic wup;
        logic rwrn;
        logic twrn;
        logic rerr;
        logic terr;
        logic boff;
        logic ovr;
        logic receive_full_flag;
    } cmbf_rflg_s;
    typedef struct packed {
        cmbf_tx_e tx_st;
        logic [1:0] tx_sel;
        logic [2:0] transmit_buffer_empty_flag;
        logic [2:0] txeie;
        logic [2:0] abort_request_flag;
        logic [2:0] abort_acknowledge_flag;
        logic [7:0] rank0;
        logic [7:0] rank1;
        logic [7:0] rank2;
        cmbf_rflg_s rflg;
        cmbf_rflg_s rien;
        cmbf_filt_e fmode;
        logic [1:0] hit;
        logic [31:0] pat;
        logic [31:0] msk;
        logic bg_full;
        logic [31:0] bg_id;
        logic [1:0] bg_hit;
        logic [31:0] fg_id;
        logic [31:0] prdata;
        logic pslverr;
    } cmbf_state_s;
endpackage : cmbf_pkg

/* File: cmbf_core.sv */
// CAN transmit scheduler, acceptance filter and interrupt flag core.
//
// Overview of operation
// - Three transmit buffers, four stored bytes each.
// - Each buffer has an eight-bit rank register.
// - Successful send sets empty flag, may interrupt.
// - Lowest rank value among ready buffers transmits first.
// - Selection reruns at every arbitration, retries included.
// - Abort request granted unless already transmitting or sleep acknowledged.
// - Abort acknowledge tells aborted from sent.
// - Four pattern and four mask bytes.
// - Acceptance sets full flag and lowest hit number.
// - Single mode uses whole 32-bit bank.
// - Dual mode gives two 16-bit filters.
// - Quad mode gives four 8-bit filters.
// - Closed mode never accepts a message.
// - Eleven enabled sources onto four request lines.
// - Transmit request while enabled empty flag set.
// - Receive flag and interrupt at end of frame.
// - Wakeup only with sleep acknowledge and enable.
// - Overrun sets flag and error request.
// - Warning flags when counters reach 96.
// - Passive flags when counters exceed 127.
// - Bus-off flag when transmit counter exceeds 255.
// - Copy to foreground only while full flag clear.
// - Write-one clears, ignored while condition persists.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cmbf_defines.svh"
module cmbf_core (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_ARB_START,
    input wire logic I_TX_DONE,
    input wire logic I_TX_ERROR,
    output logic O_TX_VALID,
    output logic [1:0] O_TX_BUF,
    output logic [7:0] O_TX_BYTE0,
    input wire logic I_RX_EOF,
    input wire logic I_RX_OWN,
    input wire logic [31:0] I_RX_ID,
    input wire logic I_IDE,
    input wire logic I_BUS_ACT,
    input wire logic I_SLEEP_ACK,
    input wire logic [8:0] I_REC,
    input wire logic [8:0] I_TEC,
    output logic [31:0] O_FG_ID,
    output logic [1:0] O_HIT,
    output logic O_IRQ_WAKE,
    output logic O_IRQ_ERR,
    output logic O_IRQ_RX,
    output logic O_IRQ_TX
);
    // ****************************************************************
    // Reset release and storage
    // ****************************************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [2:0] act_sync_ff;
    logic act_rise;
    cmbf_pkg::cmbf_state_s st_ff;
    cmbf_pkg::cmbf_state_s nxt_st;
    logic [7:0] txmem [`CMBF_NBUF*`CMBF_NWORD];
    logic [3:0] wr_word;
    logic [1:0] wr_buf;

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Bus activity is asynchronous; it counts when stage two is high and stage three is still low.
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            act_sync_ff <= 3'b000;
        end else if (I_CE) begin
            act_sync_ff <= {act_sync_ff[1:0], I_BUS_ACT};
        end
    end
    assign act_rise = act_sync_ff[1] & ~act_sync_ff[2];

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Masked compare over a byte-aligned field.
    function automatic logic fmatch(input logic [31:0] id, input logic [31:0] p,
                                    input logic [31:0] m, input logic [31:0] sel);
        fmatch = (((id ^ p) & ~m) & sel) == 32'h0000_0000;
    endfunction

    // Read error decode, shared by the read path of the access phase.
    function automatic logic rd_bad(input logic [11:0] a);
        case (a)
            `CMBF_OFS_RFLG, `CMBF_OFS_RIER, `CMBF_OFS_TFLG, `CMBF_OFS_TCTL,
            `CMBF_OFS_FCTL, `CMBF_OFS_PAT, `CMBF_OFS_MSK, `CMBF_OFS_RANK0,
            `CMBF_OFS_RANK1, `CMBF_OFS_RANK2, `CMBF_OFS_STAT: rd_bad = 1'b0;
            default: rd_bad = !(a >= `CMBF_OFS_TXBUF && a < `CMBF_OFS_TXEND);
        endcase
    endfunction

    function automatic logic [7:0] rank_of(input cmbf_pkg::cmbf_state_s s,
                                           input logic [1:0] b);
        unique case (b)
            2'd0: rank_of = s.rank0;
            2'd1: rank_of = s.rank1;
            default: rank_of = s.rank2;
        endcase
    endfunction

    // ****************************************************************
    // Acceptance filter
    // ****************************************************************
    logic [3:0] hits;
    logic acc;
    logic [1:0] acc_hit;
    always_comb begin
        hits = 4'h0;
        unique case (st_ff.fmode)
            cmbf_pkg::CMBF_FILT_SINGLE: begin
                hits[0] = fmatch(I_RX_ID, st_ff.pat, st_ff.msk, 32'hFFFF_FFFF);
            end
            cmbf_pkg::CMBF_FILT_DUAL: begin
                hits[0] = fmatch(I_RX_ID, st_ff.pat, st_ff.msk, 32'hFFFF_0000);
                hits[1] = fmatch(I_RX_ID, {st_ff.pat[15:0], 16'h0000},
                                 {st_ff.msk[15:0], 16'h0000}, 32'hFFFF_0000);
            end
            cmbf_pkg::CMBF_FILT_QUAD: begin
                for (int k = 0; k < 4; k++) begin
                    hits[k] = fmatch(I_RX_ID, {st_ff.pat[31-8*k -: 8], 24'h00_0000},
                                     {st_ff.msk[31-8*k -: 8], 24'h00_0000},
                                     32'hFF00_0000);
                end
            end
            cmbf_pkg::CMBF_FILT_CLOSED: begin
                hits = 4'h0;
            end
        endcase
        acc = (|hits) & ~I_RX_OWN;
        // Lowest filter number wins.
        acc_hit = hits[0] ? 2'd0 : hits[1] ? 2'd1 : hits[2] ? 2'd2 : 2'd3;
    end

    // ****************************************************************
    // Transmit scheduler: lowest rank among ready buffers
    // ****************************************************************
    logic [1:0] best;
    logic any_rdy;
    always_comb begin
        best = 2'd0;
        any_rdy = 1'b0;
        for (int b = 0; b < `CMBF_NBUF; b++) begin
            // Strict less-than keeps the lower buffer on ties.
            if (!st_ff.transmit_buffer_empty_flag[b] && !st_ff.abort_request_flag[b] &&
                (!any_rdy || rank_of(st_ff, 2'(b)) < rank_of(st_ff, best))) begin
                best = 2'(b);
                any_rdy = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic wr;
    logic rd;
    logic rd_setup;
    logic [2:0] set_txe;
    always_comb begin
        nxt_st = st_ff;
        wr = I_PSEL & I_PENABLE & I_PWRITE;
        rd = I_PSEL & I_PENABLE & ~I_PWRITE;
        rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
        set_txe = 3'h0;
        nxt_st.pslverr = 1'b0;
        // Transmit sequencing.
        unique case (st_ff.tx_st)
            cmbf_pkg::CMBF_TX_IDLE: begin
                if (I_ARB_START && any_rdy) begin
                    nxt_st.tx_sel = best;
                    nxt_st.tx_st = cmbf_pkg::CMBF_TX_BUSY;
                end
            end
            cmbf_pkg::CMBF_TX_BUSY: begin
                if (I_TX_DONE) begin
                    set_txe[st_ff.tx_sel] = 1'b1;
                    nxt_st.abort_acknowledge_flag[st_ff.tx_sel] = 1'b0;
                    nxt_st.tx_st = cmbf_pkg::CMBF_TX_IDLE;
                end else if (I_TX_ERROR) begin
                    // Retry re-arbitrates so a newer better buffer can win.
                    nxt_st.tx_st = cmbf_pkg::CMBF_TX_IDLE;
                end
            end
            default: nxt_st.tx_st = cmbf_pkg::CMBF_TX_IDLE;
        endcase
        // Abort grant for buffers not on the wire.
        for (int b = 0; b < `CMBF_NBUF; b++) begin
            if (st_ff.abort_request_flag[b] && !st_ff.transmit_buffer_empty_flag[b] && !I_SLEEP_ACK &&
                !(st_ff.tx_st == cmbf_pkg::CMBF_TX_BUSY && st_ff.tx_sel == 2'(b))) begin
                set_txe[b] = 1'b1;
                nxt_st.abort_acknowledge_flag[b] = 1'b1;
            end
            if (set_txe[b]) begin
                nxt_st.abort_request_flag[b] = 1'b0;
            end
        end
        // Reception and foreground copy.
        if (!st_ff.rflg.receive_full_flag && st_ff.bg_full && !I_SLEEP_ACK) begin
            nxt_st.fg_id = st_ff.bg_id;
            nxt_st.hit = st_ff.bg_hit;
            nxt_st.rflg.receive_full_flag = 1'b1;
            nxt_st.bg_full = 1'b0;
        end
        if (I_RX_EOF && acc) begin
            if (!st_ff.rflg.receive_full_flag) begin
                nxt_st.fg_id = I_RX_ID;
                nxt_st.hit = acc_hit;
                nxt_st.rflg.receive_full_flag = 1'b1;
            end else if (!st_ff.bg_full) begin
                nxt_st.bg_full = 1'b1;
                nxt_st.bg_id = I_RX_ID;
                nxt_st.bg_hit = acc_hit;
            end else begin
                nxt_st.rflg.ovr = 1'b1;
            end
        end
        // Register writes; write one clears, held conditions win.
        if (wr) begin
            unique case (I_PADDR)
                `CMBF_OFS_RFLG: begin
                    nxt_st.rflg = nxt_st.rflg & ~cmbf_pkg::cmbf_rflg_s'(I_PWDATA[7:0]);
                end
                `CMBF_OFS_RIER: nxt_st.rien = cmbf_pkg::cmbf_rflg_s'(I_PWDATA[7:0]);
                `CMBF_OFS_TFLG: begin
                    nxt_st.transmit_buffer_empty_flag = st_ff.transmit_buffer_empty_flag & ~I_PWDATA[2:0];
                    nxt_st.txeie = I_PWDATA[10:8];
                end
                `CMBF_OFS_TCTL: nxt_st.abort_request_flag = st_ff.abort_request_flag | (I_PWDATA[2:0] & ~st_ff.transmit_buffer_empty_flag);
                `CMBF_OFS_FCTL: nxt_st.fmode = cmbf_pkg::cmbf_filt_e'(I_PWDATA[1:0]);
                `CMBF_OFS_PAT: nxt_st.pat = I_PWDATA;
                `CMBF_OFS_MSK: nxt_st.msk = I_PWDATA;
                `CMBF_OFS_RANK0: nxt_st.rank0 = I_PWDATA[7:0];
                `CMBF_OFS_RANK1: nxt_st.rank1 = I_PWDATA[7:0];
                `CMBF_OFS_RANK2: nxt_st.rank2 = I_PWDATA[7:0];
                default: nxt_st.pslverr = !(I_PADDR >= `CMBF_OFS_TXBUF &&
                                            I_PADDR < `CMBF_OFS_TXEND);
            endcase
        end
        nxt_st.transmit_buffer_empty_flag = nxt_st.transmit_buffer_empty_flag | set_txe;
        // Hardware-held conditions set flags and block clears.
        if (I_REC >= `CMBF_WARN_LIM) nxt_st.rflg.rwrn = 1'b1;
        if (I_TEC >= `CMBF_WARN_LIM) nxt_st.rflg.twrn = 1'b1;
        if (I_REC > `CMBF_PASS_LIM) nxt_st.rflg.rerr = 1'b1;
        if (I_TEC > `CMBF_PASS_LIM) nxt_st.rflg.terr = 1'b1;
        if (I_TEC > `CMBF_BOFF_LIM) nxt_st.rflg.boff = 1'b1;
        if (act_rise && I_SLEEP_ACK && st_ff.rien.wup) nxt_st.rflg.wup = 1'b1;
        // Read data is captured in the setup cycle so it stands at the access edge.
        nxt_st.prdata = 32'h0000_0000;
        if (rd && rd_bad(I_PADDR)) begin
            nxt_st.pslverr = 1'b1;
        end
        if (rd_setup) begin
            unique case (I_PADDR)
                `CMBF_OFS_RFLG: nxt_st.prdata = {24'h00_0000, st_ff.rflg};
                `CMBF_OFS_RIER: nxt_st.prdata = {24'h00_0000, st_ff.rien};
                `CMBF_OFS_TFLG: nxt_st.prdata = {21'h0, st_ff.txeie, 5'h00, st_ff.transmit_buffer_empty_flag};
                `CMBF_OFS_TCTL: nxt_st.prdata = {21'h0, st_ff.abort_acknowledge_flag, 5'h00, st_ff.abort_request_flag};
                `CMBF_OFS_FCTL: nxt_st.prdata = {26'h0, st_ff.hit, 2'b00, st_ff.fmode};
                `CMBF_OFS_PAT: nxt_st.prdata = st_ff.pat;
                `CMBF_OFS_MSK: nxt_st.prdata = st_ff.msk;
                `CMBF_OFS_RANK0: nxt_st.prdata = {24'h00_0000, st_ff.rank0};
                `CMBF_OFS_RANK1: nxt_st.prdata = {24'h00_0000, st_ff.rank1};
                `CMBF_OFS_RANK2: nxt_st.prdata = {24'h00_0000, st_ff.rank2};
                `CMBF_OFS_STAT: nxt_st.prdata = {28'h0, st_ff.bg_full, 1'b0, st_ff.tx_sel};
                default: begin
                    nxt_st.prdata = {txmem[{wr_buf, wr_word[1:0]}],
                                     txmem[{wr_buf, wr_word[1:0]}],
                                     txmem[{wr_buf, wr_word[1:0]}],
                                     txmem[{wr_buf, wr_word[1:0]}]};
                end
            endcase
        end
    end

    // ****************************************************************
    // State registers and transmit buffer storage
    // ****************************************************************
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.transmit_buffer_empty_flag <= `CMBF_TXE_RST;
        end else if (I_CE) begin
            st_ff <= nxt_st;
        end
    end

    // Buffer image: four words of 32 bytes slot per buffer; bytes kept low lane.
    assign wr_buf = 2'((I_PADDR - `CMBF_OFS_TXBUF) >> 5);
    assign wr_word = 4'((I_PADDR - `CMBF_OFS_TXBUF) >> 2);
    always_ff @(posedge I_CLK) begin
        if (I_CE && wr && I_PADDR >= `CMBF_OFS_TXBUF && I_PADDR < `CMBF_OFS_TXEND &&
            st_ff.transmit_buffer_empty_flag[wr_buf]) begin
            txmem[{wr_buf, wr_word[1:0]}] <= I_PWDATA[7:0];
        end
    end

    // ****************************************************************
    // Outputs and interrupt request lines
    // ****************************************************************
    assign O_PREADY = 1'b1;
    assign O_PRDATA = st_ff.prdata;
    assign O_PSLVERR = nxt_st.pslverr & I_PSEL & I_PENABLE;
    assign O_TX_VALID = st_ff.tx_st == cmbf_pkg::CMBF_TX_BUSY;
    assign O_TX_BUF = st_ff.tx_sel;
    assign O_TX_BYTE0 = txmem[{st_ff.tx_sel, 2'b00}];
    assign O_FG_ID = st_ff.fg_id;
    assign O_HIT = st_ff.hit;
    assign O_IRQ_WAKE = st_ff.rflg.wup & st_ff.rien.wup;
    assign O_IRQ_ERR = |({st_ff.rflg.rwrn, st_ff.rflg.twrn, st_ff.rflg.rerr,
                         st_ff.rflg.terr, st_ff.rflg.boff, st_ff.rflg.ovr} &
                        {st_ff.rien.rwrn, st_ff.rien.twrn, st_ff.rien.rerr,
                         st_ff.rien.terr, st_ff.rien.boff, st_ff.rien.ovr});
    assign O_IRQ_RX = st_ff.rflg.receive_full_flag & st_ff.rien.receive_full_flag;
    assign O_IRQ_TX = |(st_ff.transmit_buffer_empty_flag & st_ff.txeie);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!rst_n || !I_CE);
    AST_TX_DONE_SETS_TXE: assert property (O_TX_VALID && I_TX_DONE |=>
        st_ff.transmit_buffer_empty_flag[$past(st_ff.tx_sel)]) else $error("txe not set after send");
    AST_PICK_LOWEST: assert property (st_ff.tx_st == cmbf_pkg::CMBF_TX_IDLE && I_ARB_START
        && any_rdy |=> O_TX_BUF == $past(best)) else $error("wrong buffer picked");
    AST_ERR_RETRY: assert property (O_TX_VALID && I_TX_ERROR && !I_TX_DONE |=>
        !O_TX_VALID) else $error("no re-arbitration after error");
    AST_ABORT_ACK: assert property (O_TX_VALID && I_TX_DONE |=>
        !st_ff.abort_acknowledge_flag[$past(st_ff.tx_sel)]) else $error("abort_acknowledge_flag set on sent");
    AST_CLOSED: assert property (st_ff.fmode == cmbf_pkg::CMBF_FILT_CLOSED && !st_ff.bg_full
        && !st_ff.rflg.receive_full_flag |=> !st_ff.rflg.receive_full_flag) else $error("closed filter accepted");
    AST_TX_IRQ: assert property (O_IRQ_TX == |(st_ff.transmit_buffer_empty_flag & st_ff.txeie))
        else $error("tx request mismatch");
    AST_BOFF: assert property (I_TEC > `CMBF_BOFF_LIM |=> st_ff.rflg.boff)
        else $error("bus-off flag missing");
    AST_WARN: assert property (I_REC >= `CMBF_WARN_LIM |=> st_ff.rflg.rwrn)
        else $error("receive warning missing");
    AST_OVR: assert property (I_RX_EOF && acc && st_ff.rflg.receive_full_flag && st_ff.bg_full |=>
        st_ff.rflg.ovr) else $error("overrun not flagged");
    COV_SEND: cover property (O_TX_VALID ##[1:20] I_TX_DONE);
    COV_ABORT: cover property (st_ff.abort_request_flag != 3'h0 ##1 st_ff.abort_acknowledge_flag != 3'h0);
    COV_RX: cover property (I_RX_EOF && acc ##1 st_ff.rflg.receive_full_flag);
endmodule // cmbf_core
`default_nettype wire

/* File: cmbf_can_bus.sv */
// Behavioural model of the CAN side: arbitration, transmit results and received frames.
`timescale 1ns/1ns
`default_nettype none
module cmbf_can_bus (
    input wire logic i_clk,
    output var logic o_arb,
    output var logic o_done,
    output var logic o_err,
    output var logic o_eof,
    output var logic o_own,
    output var logic [31:0] o_id
);
    // ****************************************************************
    // Frame events
    // ****************************************************************
    initial begin
        {o_arb, o_done, o_err, o_eof, o_own} = 5'h00;
        o_id = 32'h0000_0000;
    end
    // Kind 0 opens arbitration, 1 reports a good frame, 2 a failed one.
    task automatic pulse(input int k);
        @(posedge i_clk);
        o_arb <= (k == 0);
        o_done <= (k == 1);
        o_err <= (k == 2);
        @(posedge i_clk);
        {o_arb, o_done, o_err} <= 3'h0;
    endtask
    // Once a frame is over the identifier lines show the inverse, so stale data never matches.
    task automatic frame(input logic [31:0] id, input logic own);
        @(posedge i_clk);
        o_id <= id;
        o_own <= own;
        o_eof <= 1'b1;
        @(posedge i_clk);
        o_eof <= 1'b0;
        o_own <= 1'b0;
        o_id <= ~id;
    endtask
endmodule // cmbf_can_bus
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the CAN message buffer, filter and interrupt core.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_ack = 1'b0, bus_act = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [8:0] rec = 9'h000, tec = 9'h000;
    logic [31:0] prdata, fg_id, rx_id, rd;
    logic pready, pslverr, tx_valid, irq_wake, irq_err, irq_rx, irq_tx, slv;
    logic arb, done, err, eof, own;
    logic [1:0] tx_buf, hit;
    logic [7:0] byte0;
    logic ce = 1'b1;
    logic ide = 1'b0;
    int fail_count = 0;
    int checks = 0;
    logic [1:0] f_mode [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [31:0] f_pat [8] = '{32'h1234_5678, 32'h1234_5678, 32'h1234_5678, 32'hAAAA_5555,
        32'hAAAA_5555, 32'h1122_3344, 32'h1111_1111, 32'h0000_0000};
    logic [31:0] f_msk [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF};
    logic [31:0] f_id [8] = '{32'h1234_5678, 32'h1234_5679, 32'h1234_56AA, 32'h5555_0000,
        32'hAAAA_1234, 32'h3300_0000, 32'h1100_0000, 32'h0000_1234};
    logic f_acc [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [1:0] f_hit [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [8:0] e_rec [4] = '{9'h060, 9'h05F, 9'h080, 9'h000};
    logic [8:0] e_tec [4] = '{9'h100, 9'h080, 9'h0FF, 9'h000};
    logic [7:0] e_exp [4] = '{8'h6C, 8'h28, 8'h78, 8'h00};
    always #5 clk = ~clk;
    cmbf_can_bus bus (.i_clk(clk), .o_arb(arb), .o_done(done), .o_err(err), .o_eof(eof),
        .o_own(own), .o_id(rx_id));
    cmbf_core dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ARB_START(arb),
        .I_TX_DONE(done), .I_TX_ERROR(err), .O_TX_VALID(tx_valid), .O_TX_BUF(tx_buf),
        .O_TX_BYTE0(byte0), .I_RX_EOF(eof), .I_RX_OWN(own), .I_RX_ID(rx_id), .I_IDE(ide),
        .I_BUS_ACT(bus_act), .I_SLEEP_ACK(sleep_ack), .I_REC(rec), .I_TEC(tec),
        .O_FG_ID(fg_id), .O_HIT(hit), .O_IRQ_WAKE(irq_wake), .O_IRQ_ERR(irq_err),
        .O_IRQ_RX(irq_rx), .O_IRQ_TX(irq_tx));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Read data and error are taken at the edge where pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        slv = pslverr;
        rd = prdata;
        if (n >= 50) fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("tflg_reset", rd, 32'h0000_0007);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("slverr_unmapped", slv, 32'h0000_0001);
        for (int b = 0; b < 3; b++) apb(1'b1, 12'(12'h040 + 32 * b), 32'(8'hA0 + b));
        apb(1'b1, 12'h01C, 32'h0000_0005);
        apb(1'b1, 12'h020, 32'h0000_0010);
        apb(1'b1, 12'h024, 32'h0000_0010);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("rank1", rd, 32'h0000_0010);
        apb(1'b1, 12'h008, 32'h0000_0706);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("tflg_ready", rd, 32'h0000_0701);
        chk("irq_tx_on", irq_tx, 32'h0000_0001);
        bus.pulse(0);
        @(negedge clk);
        chk("tx_tie", {tx_valid, tx_buf, byte0}, {1'b1, 2'h1, 8'hA1});
        bus.pulse(2);
        apb(1'b1, 12'h008, 32'h0000_0701);
        @(negedge clk);
        chk("irq_tx_off", irq_tx, 32'h0000_0000);
        bus.pulse(0);
        @(negedge clk);
        chk("tx_retry", {tx_valid, tx_buf, byte0}, {1'b1, 2'h0, 8'hA0});
        apb(1'b1, 12'h00C, 32'h0000_0005);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("abort_acknowledge_flag_grant", {rd[10], rd[8]}, 32'h0000_0002);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("tflg_abort", rd, 32'h0000_0704);
        bus.pulse(1);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("abort_acknowledge_flag_sent", rd[8], 32'h0000_0000);
        chk("irq_tx_done", irq_tx, 32'h0000_0001);
        bus.pulse(0);
        @(negedge clk);
        chk("tx_last", {tx_valid, tx_buf, byte0}, {1'b1, 2'h1, 8'hA1});
        bus.pulse(1);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("tflg_all", rd, 32'h0000_0707);
        apb(1'b1, 12'h004, 32'h0000_00FF);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h010, 32'(f_mode[i]));
            apb(1'b1, 12'h014, f_pat[i]);
            apb(1'b1, 12'h018, f_msk[i]);
            bus.frame(f_id[i], 1'b0);
            @(negedge clk);
            chk("rx_irq", irq_rx, 32'(f_acc[i]));
            if (f_acc[i]) begin
                chk("hit", hit, 32'(f_hit[i]));
                chk("fg_id", fg_id, f_id[i]);
            end
            apb(1'b1, 12'h000, 32'h0000_0001);
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk("rxf_clear", rd[0], 32'h0000_0000);
        end
        apb(1'b1, 12'h010, 32'h0000_0000);
        for (int i = 1; i < 4; i++) bus.frame(32'(i), 1'b0);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("overrun", rd[7:0], 32'h0000_0003);
        chk("overrun_fg", fg_id, 32'h0000_0001);
        chk("overrun_irq", irq_err, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_0003);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("bg_copy", {rd[7:0], fg_id}, {8'h01, 32'h0000_0002});
        apb(1'b1, 12'h000, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            rec <= e_rec[i];
            tec <= e_tec[i];
            apb(1'b1, 12'h000, 32'h0000_00FF);
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk("err_flags", rd[7:0], 32'(e_exp[i]));
            chk("irq_err", irq_err, 32'(e_exp[i] != 8'h00));
        end
        // Activity is slow to show because it crosses three synchronising flops.
        for (int s = 0; s < 2; s++) begin
            sleep_ack <= s[0];
            bus_act <= 1'b1;
            repeat (2) @(posedge clk);
            bus_act <= 1'b0;
            repeat (5) @(posedge clk);
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk("wakeup", {rd[7], irq_wake}, {s[0], s[0]});
        end
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule // tb
`default_nettype wire
